// file: logic/touch_pkg.sv
// Constants shared by the touch converter control logic
package touch_pkg;
  // Serial frame: one start bit, then seven control bits, MSB first
  localparam int unsigned CMD_BITS     = 8;
  localparam int unsigned CFG_BITS     = 7;
  localparam logic [3:0]  CFG_LAST_IDX = 4'h6;
  // Field positions inside the seven control bits after the start bit
  localparam int unsigned CH_MSB_POS   = 6;
  localparam int unsigned CH_LSB_POS   = 4;
  localparam int unsigned MODE_POS     = 3;
  localparam int unsigned SER_POS      = 2;
  localparam int unsigned PD1_POS      = 1;
  localparam int unsigned PD0_POS      = 0;
  // Reset configuration: single-ended, channel 000, reference and converter power bits clear
  localparam logic [6:0]  CFG_RESET    = 7'h04;

  // Conversion timing in serial clock cycles
  localparam logic [1:0]  ACQ_LAST     = 2'h2;
  localparam int unsigned RESULT_BITS  = 12;
  localparam logic [3:0]  RESULT_LAST  = 4'hb;
  localparam logic [11:0] TRIAL_FIRST  = 12'h800;

  // Result buffer
  localparam int unsigned FIFO_WIDTH   = 12;
  localparam int unsigned FIFO_DEPTH   = 4;

  // Channel codes
  localparam logic [2:0]  CH_TEMP_LOW  = 3'h0;
  localparam logic [2:0]  CH_Y_POS     = 3'h1;
  localparam logic [2:0]  CH_BATTERY   = 3'h2;
  localparam logic [2:0]  CH_Z1        = 3'h3;
  localparam logic [2:0]  CH_Z2        = 3'h4;
  localparam logic [2:0]  CH_X_POS     = 3'h5;
  localparam logic [2:0]  CH_AUX       = 3'h6;
  localparam logic [2:0]  CH_TEMP_HIGH = 3'h7;

  // Converter positive input selection
  localparam logic [2:0]  IN_TEMP      = 3'h0;
  localparam logic [2:0]  IN_XP        = 3'h1;
  localparam logic [2:0]  IN_BATTERY   = 3'h2;
  localparam logic [2:0]  IN_YN        = 3'h3;
  localparam logic [2:0]  IN_YP        = 3'h4;
  localparam logic [2:0]  IN_AUX       = 3'h5;

  // Reference selections
  localparam logic [1:0]  REFP_VREF    = 2'h0;
  localparam logic [1:0]  REFP_YP      = 2'h1;
  localparam logic [1:0]  REFP_XP      = 2'h2;
  localparam logic [1:0]  REFN_GND     = 2'h0;
  localparam logic [1:0]  REFN_YN      = 2'h1;
  localparam logic [1:0]  REFN_XN      = 2'h2;

  // Driver bit order {xp, xn, yp, yn}
  localparam logic [3:0]  DRV_NONE     = 4'h0;
  localparam logic [3:0]  DRV_Y_PAIR   = 4'h3;
  localparam logic [3:0]  DRV_YP_XN    = 4'h6;
  localparam logic [3:0]  DRV_X_PAIR   = 4'hc;
endpackage

// file: logic/touch_adc_mux_control.sv
// Touch converter serial port, SAR sequencer, multiplexer control and result buffer
module result_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX   = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_o  = (count != FULL_COUNT);
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_idx];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_idx] <= in_data_i;
    end
  end

  // Index wrap handles depths that are not a power of two
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_idx <= '0;
      rd_idx <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule

module touch_adc_mux_control (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        cs_n_i,
  input  wire logic        serial_conv_clock_i,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             dout_oe_n_o,
  output logic             busy_o,
  output logic             busy_oe_n_o,
  input  wire logic        pen_touch_i,
  output logic             pen_touch_irq_n_o,
  output logic             pen_touch_irq_oe_n_o,
  input  wire logic        comp_i,
  output logic [11:0]      dac_trial_o,
  output logic             acquire_o,
  output logic             converter_power_on_o,
  output logic             int_ref_en_o,
  output logic [2:0]       adc_pos_sel_o,
  output logic             temp_diode_high_current_o,
  output logic [1:0]       ref_pos_sel_o,
  output logic [1:0]       ref_neg_sel_o,
  output logic             xp_drv_o,
  output logic             xn_drv_o,
  output logic             yp_drv_o,
  output logic             yn_drv_o,
  output logic             result_valid_o,
  input  wire logic        result_ready_i,
  output logic [11:0]      result_data_o
);
  typedef enum logic [2:0] {IDLE, CMD, STALL, ACQ, CONV} seq_state_t;

  seq_state_t  state;
  logic        cs_meta, cs_sync, sclk_meta, sclk_sync, sclk_prev, din_meta, din_sync, pen_meta, pen_sync;
  logic        cs_low, sclk_rise, sclk_fall, active, cmd_done;
  logic [3:0]  bit_cnt;
  logic [1:0]  acq_cnt;
  logic [5:0]  cmd_shift;
  logic [6:0]  cfg;
  logic [11:0] result;
  logic [11:0] mask;
  logic [11:0] next_result;
  logic        push_valid, push_ready;
  logic [11:0] push_data;
  logic [3:0]  drv;
  logic [2:0]  ch_sel;

  // Driver pattern per channel code; both reference modes use the same pairs
  function automatic logic [3:0] drivers_for(input logic [2:0] ch);
    unique case (ch)
      touch_pkg::CH_Y_POS:                 drivers_for = touch_pkg::DRV_Y_PAIR;
      touch_pkg::CH_Z1, touch_pkg::CH_Z2:  drivers_for = touch_pkg::DRV_YP_XN;
      touch_pkg::CH_X_POS:                 drivers_for = touch_pkg::DRV_X_PAIR;
      default:                             drivers_for = touch_pkg::DRV_NONE;
    endcase
  endfunction

  // Single-ended input routing
  function automatic logic [2:0] input_for(input logic [2:0] ch);
    unique case (ch)
      touch_pkg::CH_Y_POS, touch_pkg::CH_Z1:          input_for = touch_pkg::IN_XP;
      touch_pkg::CH_BATTERY:                          input_for = touch_pkg::IN_BATTERY;
      touch_pkg::CH_Z2:                               input_for = touch_pkg::IN_YN;
      touch_pkg::CH_X_POS:                            input_for = touch_pkg::IN_YP;
      touch_pkg::CH_AUX:                              input_for = touch_pkg::IN_AUX;
      touch_pkg::CH_TEMP_LOW, touch_pkg::CH_TEMP_HIGH: input_for = touch_pkg::IN_TEMP;
    endcase
  endfunction

  // Pins arrive asynchronously; only the second stage is looked at
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs_meta   <= 1'b1;
      cs_sync   <= 1'b1;
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      din_meta  <= 1'b0;
      din_sync  <= 1'b0;
      pen_meta  <= 1'b0;
      pen_sync  <= 1'b0;
    end else begin
      cs_meta   <= cs_n_i;
      cs_sync   <= cs_meta;
      sclk_meta <= serial_conv_clock_i;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      din_meta  <= din_i;
      din_sync  <= din_meta;
      pen_meta  <= pen_touch_i;
      pen_sync  <= pen_meta;
    end
  end

  // Serial clock edges; data and clock share the same sync delay so they stay aligned
  assign cs_low    = !cs_sync;
  assign sclk_rise = cs_low && sclk_sync && !sclk_prev;
  assign sclk_fall = cs_low && !sclk_sync && sclk_prev;
  assign active    = (state == ACQ) || (state == STALL) || (state == CONV);
  assign cmd_done  = (state == CMD) && sclk_rise && (bit_cnt == touch_pkg::CFG_LAST_IDX);

  // Sequencer: no progress without chip select low, nor without serial clock edges except when leaving STALL
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !cs_low) begin
      state <= IDLE;
    end else begin
      unique case (state)
        IDLE:  if (sclk_rise && din_sync) state <= CMD;
        CMD:   if (cmd_done) state <= push_ready ? ACQ : STALL;
        STALL: if (push_ready) state <= ACQ;                              // Full buffer holds off the next sample
        ACQ:   if (sclk_fall && acq_cnt == touch_pkg::ACQ_LAST) state <= CONV;
        CONV:  if (sclk_fall && bit_cnt == '0) state <= IDLE;
      endcase
    end
  end

  // Bit and acquisition counters
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !cs_low) begin
      bit_cnt <= '0;
      acq_cnt <= '0;
    end else begin
      if (state == IDLE) begin
        bit_cnt <= '0;
      end else if (state == CMD && sclk_rise) begin
        bit_cnt <= cmd_done ? touch_pkg::RESULT_LAST : bit_cnt + 1'b1;
      end else if (state == CONV && sclk_fall && bit_cnt != '0) begin
        bit_cnt <= bit_cnt - 1'b1;
      end
      if (state != ACQ) begin
        acq_cnt <= '0;
      end else if (sclk_fall) begin
        acq_cnt <= acq_cnt + 1'b1;
      end
    end
  end

  // Control bits shift in MSB first after the start bit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_shift <= '0;
    end else if (state == CMD && sclk_rise) begin
      cmd_shift <= {cmd_shift[4:0], din_sync};
    end
  end

  // Configuration is applied only once a whole control byte arrived
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg <= touch_pkg::CFG_RESET;
    end else if (cmd_done) begin
      cfg <= {cmd_shift, din_sync};
    end
  end

  // Internal reference follows the reference power bit
  assign int_ref_en_o = cfg[touch_pkg::PD1_POS];

  // SAR step: keep each trial bit the comparator accepts, MSB downward
  always_comb begin
    next_result = result;
    if (comp_i) begin
      next_result = result | mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result      <= '0;
      mask        <= '0;
      dac_trial_o <= '0;
    end else if (state == ACQ && sclk_fall && acq_cnt == touch_pkg::ACQ_LAST) begin
      result      <= '0;
      mask        <= touch_pkg::TRIAL_FIRST;
      dac_trial_o <= touch_pkg::TRIAL_FIRST;
    end else if (state == CONV && sclk_fall) begin
      result      <= next_result;
      mask        <= mask >> 1;
      dac_trial_o <= next_result | (mask >> 1);
    end
  end

  // Result bits leave on falling edges; trailing bits read zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !cs_low) begin
      dout_o <= 1'b0;
    end else if (sclk_fall) begin
      dout_o <= (state == CONV) ? comp_i : 1'b0;
    end
  end

  // Pins are released whenever chip select is high
  assign dout_oe_n_o = !cs_low;
  assign busy_oe_n_o = !cs_low;

  // Busy spans acquisition and any stall waiting for buffer room
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_o    <= 1'b0;
      acquire_o <= 1'b0;
    end else begin
      busy_o    <= cs_low && (state == ACQ || state == STALL);
      acquire_o <= cs_low && state == ACQ;
    end
  end

  // Finished word goes to the buffer; aborted conversions never push
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      push_valid <= 1'b0;
      push_data  <= '0;
    end else begin
      push_valid <= cs_low && state == CONV && sclk_fall && bit_cnt == '0;
      push_data  <= next_result;
    end
  end

  result_fifo #(
    .WIDTH (touch_pkg::FIFO_WIDTH),
    .DEPTH (touch_pkg::FIFO_DEPTH)
  ) result_fifo_i (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (result_valid_o),
    .out_ready_i (result_ready_i),
    .out_data_o  (result_data_o)
  );

  // Converter powers down with chip select high, else stays up if asked
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      converter_power_on_o <= 1'b0;
    end else begin
      converter_power_on_o <= cs_low && (active || cfg[touch_pkg::PD0_POS]);
    end
  end

  // Channel field of the applied configuration
  assign ch_sel = cfg[touch_pkg::CH_MSB_POS:touch_pkg::CH_LSB_POS];

  // Drivers: on while sampling, or held on by the converter power bit
  assign drv = (active || cfg[touch_pkg::PD0_POS]) ? drivers_for(ch_sel) : touch_pkg::DRV_NONE;

  // Mux and reference routing, registered so the analog side sees clean levels
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {xp_drv_o, xn_drv_o, yp_drv_o, yn_drv_o} <= touch_pkg::DRV_NONE;
      adc_pos_sel_o             <= touch_pkg::IN_TEMP;
      temp_diode_high_current_o <= 1'b0;
      ref_pos_sel_o             <= touch_pkg::REFP_VREF;
      ref_neg_sel_o             <= touch_pkg::REFN_GND;
    end else begin
      {xp_drv_o, xn_drv_o, yp_drv_o, yn_drv_o} <= drv;
      adc_pos_sel_o             <= input_for(ch_sel);
      temp_diode_high_current_o <= (ch_sel == touch_pkg::CH_TEMP_HIGH);
      ref_pos_sel_o             <= touch_pkg::REFP_VREF;
      ref_neg_sel_o             <= touch_pkg::REFN_GND;
      // Differential codes outside the four valid ones fall back to the internal path
      if (!cfg[touch_pkg::SER_POS]) begin
        unique case (ch_sel)
          touch_pkg::CH_Y_POS: begin
            ref_pos_sel_o <= touch_pkg::REFP_YP;
            ref_neg_sel_o <= touch_pkg::REFN_YN;
          end
          touch_pkg::CH_Z1, touch_pkg::CH_Z2: begin
            ref_pos_sel_o <= touch_pkg::REFP_YP;
            ref_neg_sel_o <= touch_pkg::REFN_XN;
          end
          touch_pkg::CH_X_POS: begin
            ref_pos_sel_o <= touch_pkg::REFP_XP;
            ref_neg_sel_o <= touch_pkg::REFN_XN;
          end
          default: begin
            ref_pos_sel_o <= touch_pkg::REFP_VREF;
            ref_neg_sel_o <= touch_pkg::REFN_GND;
          end
        endcase
      end
    end
  end

  // Pen line only ever pulls low; the detector is blind while drivers run
  assign pen_touch_irq_n_o = 1'b0;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pen_touch_irq_oe_n_o <= 1'b1;
    end else begin
      pen_touch_irq_oe_n_o <= !(pen_sync && drv == touch_pkg::DRV_NONE);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  dout_on_fall_a: assert property ($changed(dout_o) |-> $past(sclk_fall) || $past(!cs_low))
    else $error("data output changed without a falling serial clock");
  pins_released_a: assert property (cs_sync |-> dout_oe_n_o && busy_oe_n_o)
    else $error("outputs driven while chip select high");
  din_capture_a: assert property (state == CMD && sclk_rise |=> cmd_shift[0] == $past(din_sync))
    else $error("input bit not captured on rising edge");
  cs_abort_a: assert property (cs_sync |=> state == IDLE && !busy_o ##1 !push_valid)
    else $error("sequence continued with chip select high");
  adc_powerdown_a: assert property (cs_sync ##1 cs_sync |-> !converter_power_on_o)
    else $error("converter powered while chip select high");
  conv_step_a: assert property (state == CONV && !sclk_fall |=> $stable(result))
    else $error("conversion advanced without serial clock");
  acq_three_a: assert property (state == ACQ && sclk_fall && acq_cnt == touch_pkg::ACQ_LAST
    |=> state == CONV && mask == touch_pkg::TRIAL_FIRST)
    else $error("acquisition did not end after three cycles");
  ref_power_a: assert property (cmd_done |=> int_ref_en_o == $past(cmd_shift[0]))
    else $error("internal reference does not follow its bit");
  hold_drivers_a: assert property (cfg[touch_pkg::PD0_POS] && ch_sel == touch_pkg::CH_X_POS
    |=> xp_drv_o && xn_drv_o && !yp_drv_o)
    else $error("drivers dropped with converter power bit set");
  pen_open_drain_a: assert property (!pen_touch_irq_oe_n_o |-> pen_touch_irq_n_o == 1'b0 && $past(pen_sync))
    else $error("pen line driven high or without touch");
endmodule

// file: bench/host_model.sv
// Host side serial controller that frames commands and collects results
module host_model (
  input  wire logic clk_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      din_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period in system clocks, well above the three-cycle minimum level
  localparam int HALF = 8;

  // Serial clock stands still low and chip select idles high outside frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Bits are set up while the clock is low and taken on the rise
  task automatic send_cmd(input logic [7:0] cmd, input int nbits);
    int i;
    cs_n_o <= 1'b0;
    wait_clk(HALF);
    for (i = 0; i < nbits; i++) begin
      din_o <= cmd[7-i];
      wait_clk(HALF);
      sclk_o <= 1'b1;
      wait_clk(HALF);
      if (i < nbits - 1) sclk_o <= 1'b0;
    end
  endtask

  // Host keeps clocking so acquisition and conversion advance
  task automatic read_result(output logic [11:0] bits);
    int j;
    for (j = 0; j < 15; j++) begin
      sclk_o <= 1'b0;
      din_o  <= 1'b0;
      wait_clk(HALF);
      sclk_o <= 1'b1;
      wait_clk(HALF);
      // Sampled late in the high phase, long after the falling-edge update
      if (j > 2) bits[14-j] = dout_oe_n_i ? 1'bz : dout_i;
    end
  endtask

  // Last fall, then deselect; also aborts a partial command
  task automatic end_frame();
    sclk_o <= 1'b0;
    wait_clk(HALF);
    cs_n_o <= 1'b1;
    din_o  <= 1'b0;
    wait_clk(HALF);
  endtask
endmodule

// file: bench/touch_adc_mux_control_tb.sv
// Self-checking bench for the touch converter control block
module touch_adc_mux_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] EXP_POS [8] = '{touch_pkg::IN_TEMP, touch_pkg::IN_XP, touch_pkg::IN_BATTERY,
    touch_pkg::IN_XP, touch_pkg::IN_YN, touch_pkg::IN_YP, touch_pkg::IN_AUX, touch_pkg::IN_TEMP};
  localparam logic [3:0] EXP_DRV [8] = '{touch_pkg::DRV_NONE, touch_pkg::DRV_Y_PAIR, touch_pkg::DRV_NONE,
    touch_pkg::DRV_YP_XN, touch_pkg::DRV_YP_XN, touch_pkg::DRV_X_PAIR, touch_pkg::DRV_NONE, touch_pkg::DRV_NONE};
  // Packed as {positive reference, negative reference}
  localparam logic [3:0] DIF_REF [8] = '{4'h0, 4'h5, 4'h0, 4'h6, 4'h6, 4'ha, 4'h0, 4'h0};
  localparam logic [2:0] DIF_CH [4] = '{3'h1, 3'h3, 3'h4, 3'h5};
  localparam logic [11:0] DIF_VAL [4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};

  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cs_n, sclk, din, dout, dout_oe_n, busy, busy_oe_n;
  logic        pen_touch = 1'b0;
  logic        irq_n, irq_oe_n, comp, acquire, conv_pwr, int_ref, temp_hi;
  logic        xp, xn, yp, yn, res_valid;
  logic        res_ready = 1'b0;
  logic [11:0] dac_trial, res_data;
  logic [11:0] analog = 12'h000;
  logic [2:0]  pos_sel;
  logic [1:0]  refp, refn;
  int          errors = 0;
  int          checks = 0;
  int          i;
  logic [11:0] bits;

  always #12.5 clk_i = ~clk_i;

  // Ideal comparator on a fixed input level, so the result must equal it
  assign comp = (analog >= dac_trial);

  host_model host_model_i (.clk_i(clk_i), .dout_i(dout), .dout_oe_n_i(dout_oe_n), .cs_n_o(cs_n),
    .sclk_o(sclk), .din_o(din));

  touch_adc_mux_control touch_adc_mux_control_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n),
    .serial_conv_clock_i(sclk), .din_i(din), .dout_o(dout), .dout_oe_n_o(dout_oe_n), .busy_o(busy),
    .busy_oe_n_o(busy_oe_n), .pen_touch_i(pen_touch), .pen_touch_irq_n_o(irq_n),
    .pen_touch_irq_oe_n_o(irq_oe_n), .comp_i(comp), .dac_trial_o(dac_trial), .acquire_o(acquire),
    .converter_power_on_o(conv_pwr), .int_ref_en_o(int_ref), .adc_pos_sel_o(pos_sel),
    .temp_diode_high_current_o(temp_hi), .ref_pos_sel_o(refp), .ref_neg_sel_o(refn), .xp_drv_o(xp),
    .xn_drv_o(xn), .yp_drv_o(yp), .yn_drv_o(yn), .result_valid_o(res_valid), .result_ready_i(res_ready),
    .result_data_o(res_data));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Pop one buffered word and compare it
  task automatic drain(input logic [11:0] a);
    check(res_valid, 1'b1, "buffer valid");
    check(res_data, a, "buffer data");
    res_ready <= 1'b1;
    @(posedge clk_i);
    res_ready <= 1'b0;
    @(posedge clk_i);
  endtask

  // One full conversion frame with configuration checks during acquisition
  task automatic conv(input logic [2:0] ch, input logic ser, input logic pd1, input logic pd0,
                      input logic [11:0] a, input bit pop);
    logic [11:0] bits;
    analog <= a;
    host_model_i.send_cmd({1'b1, ch, 1'b0, ser, pd1, pd0}, 8);
    repeat (6) @(posedge clk_i);
    check(pos_sel, EXP_POS[ch], "input select");
    check({xp, xn, yp, yn}, EXP_DRV[ch], "drivers");
    check({refp, refn}, ser ? 4'h0 : DIF_REF[ch], "references");
    check(temp_hi, ch == 3'h7, "diode current");
    check(int_ref, pd1, "reference power");
    check({acquire, busy, dout_oe_n, busy_oe_n, conv_pwr}, 5'h19, "acquire state");
    host_model_i.read_result(bits);
    check(bits, a, "serial result");
    host_model_i.end_frame();
    check({dout_oe_n, busy_oe_n, conv_pwr}, 3'h6, "released");
    check({xp, xn, yp, yn}, pd0 ? EXP_DRV[ch] : touch_pkg::DRV_NONE, "drivers after");
    if (pop) drain(a);
  endtask

  // Hang guard, far beyond the roughly 7400 cycles the tests need
  initial begin
    #1000000;
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check({dout_oe_n, busy_oe_n, irq_oe_n, int_ref, conv_pwr, res_valid, xp, xn, yp, yn}, 10'h380,
          "reset outputs");
    $display("test reset done");
    // Pen line is only ever pulled low, and released when untouched
    pen_touch <= 1'b1;
    repeat (8) @(posedge clk_i);
    check({irq_n, irq_oe_n}, 2'h0, "pen pull");
    pen_touch <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(irq_oe_n, 1'b1, "pen release");
    $display("test pen done");
    // Every single-ended code; the first command clears reference power
    for (i = 0; i < 8; i++) conv(i[2:0], 1'b1, i[0], 1'b0, {i[2:0], 9'h135}, 1'b1);
    $display("test single-ended done");
    // Differential codes, alternating the keep-powered bit
    for (i = 0; i < 4; i++) conv(DIF_CH[i], 1'b0, 1'b0, i[0], DIF_VAL[i], 1'b1);
    // Drivers held on by the last command keep the pen line quiet
    pen_touch <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(irq_oe_n, 1'b1, "pen masked by drivers");
    pen_touch <= 1'b0;
    // A differential code outside the valid four falls back to the internal references
    conv(3'h6, 1'b0, 1'b0, 1'b0, 12'h5a5, 1'b1);
    $display("test differential done");
    // Partial command then deselect: nothing converted or buffered
    host_model_i.send_cmd(8'hd4, 4);
    host_model_i.end_frame();
    repeat (40) @(posedge clk_i);
    check({res_valid, dout_oe_n, busy_oe_n}, 3'h3, "abort");
    $display("test abort done");
    // Fill the buffer, see the sequencer refuse, then drain in order
    for (i = 0; i < 4; i++) conv(DIF_CH[i], 1'b0, 1'b0, 1'b0, DIF_VAL[i], 1'b0);
    host_model_i.send_cmd(8'h94, 8);
    repeat (6) @(posedge clk_i);
    check({busy, acquire}, 2'h2, "stall when full");
    // Freeing one slot lets the stalled frame acquire and convert
    drain(DIF_VAL[0]);
    host_model_i.read_result(bits);
    check(bits, DIF_VAL[3], "result after stall");
    host_model_i.end_frame();
    for (i = 1; i < 4; i++) drain(DIF_VAL[i]);
    drain(DIF_VAL[3]);
    check(res_valid, 1'b0, "buffer empty");
    $display("test buffer done");
    summarize();
  end
endmodule
